// ### dbu_bit_rmw.sv
// Purpose: Masked set or toggle of one image RAM byte
// Assumes: RAM read data valid the cycle after ram_rd_en
// Notes:   Four cycles from start to done
`timescale 1ns/10ps
module dbu_bit_rmw (
   input  wire logic         clock,       // Core clock
   input  wire logic         resetn,      // Async reset, low
   input  wire logic         start,       // Begin operation
   input  dbu_pkg::dbu_bitop_t req,       // Address, mask, mode
   output logic [15:0]       ram_addr,    // RAM address
   output logic              ram_rd_en,   // RAM read strobe
   input  wire logic [7:0]   ram_rd_data, // RAM read data
   output logic              ram_wr_en,   // RAM write strobe
   output logic [7:0]        ram_wr_data, // RAM write data
   output logic              done         // Operation finished
);
   import dbu_pkg::*;

   typedef enum logic [3:0] {
      RM_IDLE = 4'h1,
      RM_READ = 4'h2,
      RM_CALC = 4'h4,
      RM_WRITE = 4'h8
   } dbu_rm_state_t;

   dbu_rm_state_t st_reg;    // Sequence state
   dbu_rm_state_t st_next;   // Next state
   dbu_bitop_t    req_reg;   // Latched request
   logic [7:0]    wd_reg;    // Modified byte
   logic          done_reg;  // Finish pulse

   // [RULE1] Set masked bits
   wire [7:0] set_val = ram_rd_data | req_reg.mask;
   // [RULE2] Toggle masked bits
   wire [7:0] xor_val = ram_rd_data ^ req_reg.mask;

   assign ram_addr    = req_reg.addr;
   assign ram_rd_en   = (st_reg == RM_READ);
   assign ram_wr_en   = (st_reg == RM_WRITE);
   assign ram_wr_data = wd_reg;
   assign done        = done_reg;

   // Next state
   always_comb begin
      case (st_reg)
         RM_IDLE:  st_next = start ? RM_READ : RM_IDLE;
         RM_READ:  st_next = RM_CALC;
         RM_CALC:  st_next = RM_WRITE;
         RM_WRITE: st_next = RM_IDLE;
         default:  st_next = RM_IDLE;
      endcase
   end

   // State, request latch and result
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_reg   <= RM_IDLE;
         req_reg  <= '0;
         wd_reg   <= 8'h00;
         done_reg <= 1'b0;
      end else begin
         st_reg   <= st_next;
         done_reg <= (st_reg == RM_WRITE);
         if (st_reg == RM_IDLE && start)
            req_reg <= req;
         if (st_reg == RM_CALC)
            wd_reg <= req_reg.toggle ? xor_val : set_val;
      end
   end
endmodule : dbu_bit_rmw

// ### dbu_cmd_top.sv
// Purpose: Bit-op, clear, refresh and sleep command execution
// Assumes: Byte decoder, image RAM and panel sequencer on same clock
// Notes:   One command at a time; cmd_busy covers variable latency
//
// Overview of operation
// [RULE1] Opcode 09 sets masked RAM bits
// [RULE2] Opcode 0A toggles masked RAM bits
// [RULE3] Opcode 10 clears all bright
// [RULE4] Opcode 11 bright, border dark
// [RULE5] Opcode 12 clears all dark
// [RULE6] Opcode 13 dark, border bright
// [RULE7] Opcode 14 clears rows bright
// [RULE8] Opcode 15 rows bright, border dark
// [RULE9] Opcode 16 clears rows dark
// [RULE10] Opcode 17 rows dark, border bright
// [RULE11] Host keeps rows 0..159, span 80
// [RULE12] Two-byte arguments arrive high byte first
// [RULE13] Opcode 18 refreshes whole panel from buffer
// [RULE14] Opcode 19 refreshes row range from buffer
// [RULE15] Host keeps refresh rows legal
// [RULE16] Completion signalled, not fixed latency
// [RULE17] Opcode 20 enters sleep mode
// [RULE18] Chip select rise ends arguments
// [RULE19] Illegal row ranges are ignored
`timescale 1ns/10ps
module dbu_cmd_top (
   input  wire logic           clock,         // Core clock, 40 MHz
   input  wire logic           resetn,        // Async reset, low
   input  wire logic           rx_valid,      // Command byte strobe
   input  wire logic [7:0]     rx_byte,       // Command byte
   input  wire logic           frame_end,     // Chip select rose
   output logic [15:0]         ram_addr,      // Image RAM address
   output logic                ram_rd_en,     // Image RAM read
   input  wire logic [7:0]     ram_rd_data,   // Image RAM data in
   output logic                ram_wr_en,     // Image RAM write
   output logic [7:0]          ram_wr_data,   // Image RAM data out
   output logic                panel_valid,   // Panel op offered
   output dbu_pkg::dbu_panel_op_t panel_op,   // Panel op fields
   input  wire logic           panel_ready,   // Sequencer accepts
   input  wire logic           panel_done,    // Sequencer finished
   output logic                sleep_mode,    // Low-power request
   output logic                cmd_busy,      // Command executing
   output logic                cmd_done,      // Command completed
   output logic                cmd_rejected   // Command ignored
);
   import dbu_pkg::*;

   // Top-level sequencing states
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_BITOP = 4'h2,
      ST_ISSUE = 4'h4,
      ST_WAIT  = 4'h8
   } dbu_state_t;

   dbu_state_t    st_reg;      // Current state
   dbu_state_t    st_next;     // Next state
   dbu_panel_op_t pop_reg;     // Latched panel operation
   logic          sleep_reg;   // Sleep level
   logic          done_reg;    // Completion pulse
   logic          rej_reg;     // Reject pulse
   logic          frame_valid; // Frame pending
   dbu_frame_t    frame;       // Pending frame
   logic          rmw_done;    // Bit operation finished
   dbu_bitop_t    bit_req;     // Bit operation request
   dbu_panel_op_t pop_next;    // Decoded panel operation

   // Frame taken only when idle
   wire take = frame_valid & (st_reg == ST_IDLE);

   // Frame collection from the byte stream
   dbu_frame_collect u_collect (
      .clock       (clock),
      .resetn      (resetn),
      .rx_valid    (rx_valid),
      .rx_byte     (rx_byte),
      .frame_end   (frame_end),
      .frame_ready (take),
      .frame_valid (frame_valid),
      .frame       (frame)
   );

   // Opcode classification
   wire [7:0] opc      = frame.opcode;
   wire [2:0] cnt      = frame.arg_cnt;
   wire       op_set   = (opc == set_bits_cmd);
   wire       op_xor   = (opc == xor_bits_cmd);
   wire       op_all   = (opc >= clear_all_bright_cmd) &&
                         (opc <= clear_all_dark_inv_border_cmd);
   wire       op_rows  = (opc >= clear_rows_bright_cmd) &&
                         (opc <= clear_rows_dark_inv_border_cmd);
   wire       op_full  = (opc == full_panel_refresh_cmd);
   wire       op_part  = (opc == row_range_refresh_cmd);
   wire       op_sleep = (opc == sleep_cmd);
   wire       op_ours  = op_set | op_xor | op_all | op_rows |
                         op_full | op_part | op_sleep;

   // [RULE12] High byte first
   wire [15:0] addr_w  = {frame.args[A_ADDR_H], frame.args[A_ADDR_L]};
   wire        rsel    = op_part;
   wire [15:0] first_w = rsel ?
      {frame.args[A_ROW0+2], frame.args[A_ROW0+3]} :
      {frame.args[A_ROW0],   frame.args[A_ROW0+1]};
   wire [15:0] last_w  = rsel ?
      {frame.args[A_ROW1+2], frame.args[A_ROW1+3]} :
      {frame.args[A_ROW1],   frame.args[A_ROW1+1]};

   // [RULE19] Range legality check
   wire [15:0] span_w  = last_w - first_w;
   wire        rows_ok = (first_w <= last_w) && (last_w <= ROW_LAST) &&
                         (span_w < ROW_SPAN_MAX);

   // Argument count and range checks per command
   wire ok_bit   = (op_set | op_xor) && (cnt == ARGS_BITOP);
   wire ok_all   = op_all   && (cnt == ARGS_NONE);
   wire ok_rows  = op_rows  && (cnt == ARGS_ROWS) && rows_ok;
   wire ok_full  = op_full  && (cnt == ARGS_FULL_REF);
   wire ok_part  = op_part  && (cnt == ARGS_PART_REF) && rows_ok;
   wire ok_sleep = op_sleep && (cnt == ARGS_NONE);
   wire ok_panel = ok_all | ok_rows | ok_full | ok_part;

   // [RULE3] Shade from opcode bits
   wire shade_bright = ~opc[OPC_DARK_BIT];
   // [RULE4] Border inversion bit
   wire border_shade = ~(opc[OPC_DARK_BIT] ^ opc[OPC_INV_BIT]);

   // Bit operation request from frame
   assign bit_req.toggle = op_xor;
   assign bit_req.addr   = addr_w;
   assign bit_req.mask   = frame.args[A_MASK];

   // Panel operation decode
   always_comb begin
      pop_next                 = '0;
      pop_next.buf_addr        = addr_w;
      pop_next.first_row       = ROW_FIRST[7:0];
      pop_next.last_row        = ROW_LAST[7:0];
      pop_next.interior_bright = shade_bright;
      pop_next.border_bright   = border_shade;
      if (op_all) begin
         // [RULE5] Whole panel clear
         // [RULE6] Border set by opcode
         pop_next.kind = PK_CLEAR_ALL;
      end else if (op_rows) begin
         // [RULE7] Row section clear
         // [RULE8] Section border dark
         // [RULE9] Section dark clear
         // [RULE10] Section border bright
         pop_next.kind      = PK_CLEAR_ROWS;
         pop_next.first_row = first_w[7:0];
         pop_next.last_row  = last_w[7:0];
      end else if (op_full) begin
         // [RULE13] Whole panel refresh
         pop_next.kind = PK_REFRESH_ALL;
      end else begin
         // [RULE14] Row range refresh
         pop_next.kind      = PK_REFRESH_ROWS;
         pop_next.first_row = first_w[7:0];
         pop_next.last_row  = last_w[7:0];
      end
   end

   // Masked read-modify-write engine
   dbu_bit_rmw u_rmw (
      .clock       (clock),
      .resetn      (resetn),
      .start       (take & ok_bit),
      .req         (bit_req),
      .ram_addr    (ram_addr),
      .ram_rd_en   (ram_rd_en),
      .ram_rd_data (ram_rd_data),
      .ram_wr_en   (ram_wr_en),
      .ram_wr_data (ram_wr_data),
      .done        (rmw_done)
   );

   // Next state
   always_comb begin
      case (st_reg)
         ST_IDLE: begin
            if (take && ok_bit)
               st_next = ST_BITOP;
            else if (take && ok_panel)
               st_next = ST_ISSUE;
            else
               st_next = ST_IDLE;
         end
         ST_BITOP: st_next = rmw_done ? ST_IDLE : ST_BITOP;
         ST_ISSUE: st_next = panel_ready ? ST_WAIT : ST_ISSUE;
         // [RULE16] Wait for completion
         ST_WAIT:  st_next = panel_done ? ST_IDLE : ST_WAIT;
         default:  st_next = ST_IDLE;
      endcase
   end

   // Status outputs
   assign panel_valid  = (st_reg == ST_ISSUE);
   assign panel_op     = pop_reg;
   assign sleep_mode   = sleep_reg;
   assign cmd_busy     = (st_reg != ST_IDLE) | frame_valid;
   assign cmd_done     = done_reg;
   assign cmd_rejected = rej_reg;

   // State and panel operation latch
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_reg  <= ST_IDLE;
         pop_reg <= '0;
      end else begin
         st_reg <= st_next;
         if (take && ok_panel)
            pop_reg <= pop_next;
      end
   end

   // Completion, reject and sleep
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         done_reg  <= 1'b0;
         rej_reg   <= 1'b0;
         sleep_reg <= 1'b0;
      end else begin
         // [RULE16] Completion pulse
         done_reg <= (st_reg == ST_BITOP && rmw_done) ||
                     (st_reg == ST_WAIT && panel_done) ||
                     (take && ok_sleep);
         // [RULE19] Flag ignored command
         rej_reg  <= take && op_ours && !(ok_bit | ok_panel | ok_sleep);
         // [RULE17] Enter sleep mode
         if (take && ok_sleep)
            sleep_reg <= 1'b1;
         else if (rx_valid)
            sleep_reg <= 1'b0;
      end
   end
endmodule : dbu_cmd_top

// ### dbu_cmd_top_asserts.sv
// Purpose: Concurrent checks on executor ports
// Assumes: One clock domain, async active-low reset
// Notes:   Attached to dbu_cmd_top by bind at the foot
`timescale 1ns/10ps
module dbu_cmd_top_asserts (
   input wire logic        clock,        // Core clock
   input wire logic        resetn,       // Async reset, low
   input wire logic        rx_valid,     // Byte strobe
   input wire logic        ram_rd_en,    // RAM read strobe
   input wire logic        ram_wr_en,    // RAM write strobe
   input wire logic        panel_valid,  // Panel op offered
   input dbu_pkg::dbu_panel_op_t panel_op, // Panel op fields
   input wire logic        panel_ready,  // Sequencer accepts
   input wire logic        panel_done,   // Sequencer finished
   input wire logic        sleep_mode,   // Low-power request
   input wire logic        cmd_busy,     // Command executing
   input wire logic        cmd_done,     // Completion pulse
   input wire logic        cmd_rejected  // Rejection pulse
);
   import dbu_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   // Read, write, done at fixed spacing
   sequence s_rmw;
      ram_rd_en ##2 ram_wr_en ##2 cmd_done;
   endsequence
   // Row-range ops carry a legal range only
   wire rows_op = panel_op.kind == PK_CLEAR_ROWS || panel_op.kind == PK_REFRESH_ROWS;
   a_rmw_order: assert property (ram_rd_en |-> s_rmw)
      else $error("read-modify-write steps out of order");
   a_wr_after_rd: assert property (ram_wr_en |-> $past(ram_rd_en, 2) && !ram_rd_en)
      else $error("RAM write without matching read");
   a_valid_holds: assert property (panel_valid && !panel_ready |=> panel_valid && $stable(panel_op))
      else $error("panel offer dropped or changed");
   a_done_follows: assert property (panel_done && cmd_busy && !panel_valid |=> cmd_done)
      else $error("no completion after panel finished");
   a_done_pulse: assert property (cmd_done |-> $past(cmd_busy) ##1 !cmd_done)
      else $error("completion not a single pulse");
   a_rows_legal: assert property (panel_valid && rows_op |-> panel_op.first_row <= panel_op.last_row
      && panel_op.last_row <= 8'h9F && (panel_op.last_row - panel_op.first_row) < 8'h50)
      else $error("illegal row range offered to panel");
   a_full_rows: assert property (panel_valid && !rows_op |-> panel_op.first_row == 8'h00
      && panel_op.last_row == 8'h9F)
      else $error("full panel op without full row span");
   a_reject_quiet: assert property (cmd_rejected |-> !panel_valid ##1 !panel_valid)
      else $error("panel op offered for a rejected command");
   a_sleep_done: assert property ($rose(sleep_mode) |-> cmd_done)
      else $error("sleep entered without completion");
   a_wake_byte: assert property (sleep_mode && rx_valid |=> !sleep_mode)
      else $error("sleep held after a new byte");
endmodule : dbu_cmd_top_asserts

bind dbu_cmd_top dbu_cmd_top_asserts i_dbu_cmd_top_asserts (
   .clock(clock), .resetn(resetn), .rx_valid(rx_valid), .ram_rd_en(ram_rd_en),
   .ram_wr_en(ram_wr_en), .panel_valid(panel_valid), .panel_op(panel_op),
   .panel_ready(panel_ready), .panel_done(panel_done), .sleep_mode(sleep_mode),
   .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_rejected(cmd_rejected));

// ### dbu_frame_collect.sv
// Purpose: Gather one chip-select frame into opcode and arguments
// Assumes: rx_valid/frame_end come from same-clock byte decoder
// Notes:   Frame is held until taken; bytes meanwhile are dropped
`timescale 1ns/10ps
module dbu_frame_collect (
   input  wire logic         clock,       // Core clock
   input  wire logic         resetn,      // Async reset, low
   input  wire logic         rx_valid,    // Byte strobe
   input  wire logic [7:0]   rx_byte,     // Received byte
   input  wire logic         frame_end,   // Chip select rose
   input  wire logic         frame_ready, // Consumer takes frame
   output logic              frame_valid, // Frame pending
   output dbu_pkg::dbu_frame_t frame      // Pending frame
);
   import dbu_pkg::*;

   logic [2:0] cnt_reg;    // Bytes seen in frame
   logic       pend_reg;   // Frame waiting
   logic       ovr_reg;    // Frame overran
   dbu_frame_t frm_reg;    // Frame contents
   wire        take_byte = rx_valid & ~pend_reg;
   wire        close     = frame_end & ~pend_reg & (cnt_reg != ARGS_NONE);

   assign frame_valid = pend_reg;
   assign frame       = frm_reg;

   // Byte counter; saturates so over-long frames stay invalid
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         {ovr_reg, cnt_reg} <= 4'h0;
         pend_reg <= 1'b0;
      end else begin
         if (frame_end)
            {ovr_reg, cnt_reg} <= 4'h0;
         else if (take_byte && cnt_reg != ARGS_OVERRUN)
            cnt_reg <= cnt_reg + 3'h1;
         else if (take_byte)
            ovr_reg <= 1'b1;
         if (close)
            pend_reg <= 1'b1;
         else if (frame_ready)
            pend_reg <= 1'b0;
      end
   end

   // Opcode and count capture
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         frm_reg.opcode  <= 8'h00;
         frm_reg.arg_cnt <= 3'h0;
      end else begin
         if (take_byte && cnt_reg == 3'h0)
            frm_reg.opcode <= rx_byte;
         // [RULE18] Close on rise
         if (close)
            frm_reg.arg_cnt <= ovr_reg ? ARGS_OVERRUN
                                                          : cnt_reg - 3'h1;
      end
   end

   // One slot per argument position
   genvar gi;
   generate
      for (gi = 0; gi < ARG_SLOTS; gi++) begin : g_arg
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn)
               frm_reg.args[gi] <= 8'h00;
            else if (take_byte && cnt_reg == 3'(gi + 1))
               frm_reg.args[gi] <= rx_byte;
         end
      end
   endgenerate
endmodule : dbu_frame_collect

// ### dbu_panel_model.sv
// Purpose: Image RAM and panel sequencer behind the executor
// Assumes: Same clock as the executor
// Notes:   slow stretches accept and finish times
`timescale 1ns/10ps
module dbu_panel_model (
   input wire logic           clock,       // Core clock
   input wire logic           resetn,      // Async reset, low
   input wire logic           slow,        // Stall the sequencer
   input wire logic [15:0]    ram_addr,    // RAM address
   input wire logic           ram_rd_en,   // RAM read strobe
   input wire logic           ram_wr_en,   // RAM write strobe
   input wire logic [7:0]     ram_wr_data, // RAM write data
   input wire logic           panel_valid, // Panel op offered
   input dbu_pkg::dbu_panel_op_t panel_op, // Panel op fields
   output logic [7:0]         ram_rd_data, // RAM read data
   output logic               panel_ready, // Accept pulse
   output logic               panel_done,  // Finish pulse
   output dbu_pkg::dbu_panel_op_t last_op, // Last accepted op
   output logic [15:0]        n_accept     // Accepted op count
);
   import dbu_pkg::*;
   logic [7:0] mem [0:65535]; // Image RAM, preloaded by the bench
   logic [5:0] wait_cnt;      // Stall counter
   logic       busy;          // Op in progress
   initial ram_rd_data = 8'h5A;
   // Read data valid the cycle after the strobe, else scrambled
   always @(posedge clock) begin
      if (ram_wr_en) mem[ram_addr] <= ram_wr_data;
      ram_rd_data <= ram_rd_en ? mem[ram_addr] : ~ram_rd_data;
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         panel_ready <= 1'b0;
         panel_done  <= 1'b0;
         busy        <= 1'b0;
         wait_cnt    <= 6'h00;
         n_accept    <= 16'h0000;
         last_op     <= '0;
      end else begin
         panel_ready <= 1'b0;
         panel_done  <= 1'b0;
         if (panel_valid && panel_ready) begin // Take the op
            busy     <= 1'b1;
            wait_cnt <= 6'h00;
            last_op  <= panel_op;
            n_accept <= n_accept + 16'h0001;
         end else if (busy) begin // Finish never in the accept cycle
            wait_cnt <= wait_cnt + 6'h01;
            if (wait_cnt == (slow ? 6'h14 : 6'h01)) begin
               panel_done <= 1'b1;
               busy       <= 1'b0;
               wait_cnt   <= 6'h00;
            end
         end else if (panel_valid) begin // Stall before accepting
            wait_cnt <= wait_cnt + 6'h01;
            if (wait_cnt >= (slow ? 6'h0E : 6'h00)) panel_ready <= 1'b1;
         end
      end
   end
endmodule : dbu_panel_model

// ### dbu_pkg.sv
// Purpose: Shared constants and types for the bit-op/update interpreter
// Assumes: Byte stream already deserialised on the core clock
// Notes:   Rows are 0..159; sections span at most 80 rows
package dbu_pkg;
   // Opcodes handled by this block
   localparam logic [7:0] set_bits_cmd                    = 8'h09;
   localparam logic [7:0] xor_bits_cmd                    = 8'h0A;
   localparam logic [7:0] clear_all_bright_cmd            = 8'h10;
   localparam logic [7:0] clear_all_bright_inv_border_cmd = 8'h11;
   localparam logic [7:0] clear_all_dark_cmd              = 8'h12;
   localparam logic [7:0] clear_all_dark_inv_border_cmd   = 8'h13;
   localparam logic [7:0] clear_rows_bright_cmd           = 8'h14;
   localparam logic [7:0] clear_rows_bright_inv_border_cmd = 8'h15;
   localparam logic [7:0] clear_rows_dark_cmd             = 8'h16;
   localparam logic [7:0] clear_rows_dark_inv_border_cmd  = 8'h17;
   localparam logic [7:0] full_panel_refresh_cmd          = 8'h18;
   localparam logic [7:0] row_range_refresh_cmd           = 8'h19;
   localparam logic [7:0] sleep_cmd                       = 8'h20;
   // Opcode bit that selects dark, bit that inverts the border
   localparam int OPC_DARK_BIT = 1;
   localparam int OPC_INV_BIT  = 0;
   // Argument counts per command
   localparam logic [2:0] ARGS_BITOP    = 3'h3;
   localparam logic [2:0] ARGS_NONE     = 3'h0;
   localparam logic [2:0] ARGS_ROWS     = 3'h4;
   localparam logic [2:0] ARGS_FULL_REF = 3'h2;
   localparam logic [2:0] ARGS_PART_REF = 3'h6;
   localparam logic [2:0] ARGS_OVERRUN  = 3'h7;
   localparam int         ARG_SLOTS     = 6;
   // Argument slot positions
   localparam int A_ADDR_H = 0;
   localparam int A_ADDR_L = 1;
   localparam int A_MASK   = 2;
   localparam int A_ROW0   = 0;
   localparam int A_ROW1   = 2;
   // Row limits
   localparam logic [15:0] ROW_FIRST    = 16'h0000;
   localparam logic [15:0] ROW_LAST     = 16'h009F;
   localparam logic [15:0] ROW_SPAN_MAX = 16'h0050;
   // Panel operation kinds
   typedef enum logic [1:0] {
      PK_CLEAR_ALL   = 2'h0,
      PK_CLEAR_ROWS  = 2'h1,
      PK_REFRESH_ALL = 2'h2,
      PK_REFRESH_ROWS = 2'h3
   } dbu_kind_t;
   // Collected command frame
   typedef struct packed {
      logic [7:0]                opcode;
      logic [2:0]                arg_cnt;
      logic [ARG_SLOTS-1:0][7:0] args;
   } dbu_frame_t;
   // Masked read-modify-write request
   typedef struct packed {
      logic        toggle;
      logic [15:0] addr;
      logic [7:0]  mask;
   } dbu_bitop_t;
   // Request to the panel drive sequencer
   typedef struct packed {
      dbu_kind_t   kind;
      logic        interior_bright;
      logic        border_bright;
      logic [7:0]  first_row;
      logic [7:0]  last_row;
      logic [15:0] buf_addr;
   } dbu_panel_op_t;
endpackage : dbu_pkg

// ### display_bitop_update_cmds_tb.sv
// Purpose: Directed test of bit-op, clear, refresh and sleep commands
// Assumes: Frames driven as byte strobes plus a closing pulse
// Notes:   Each command waits for idle and its own completion or rejection
`timescale 1ns/10ps
module display_bitop_update_cmds_tb;
   import dbu_pkg::*;
   typedef logic [7:0] dbu_bytes_t [7]; // One command frame
   logic          clock, resetn, rx_valid, frame_end, slow;
   logic [7:0]    rx_byte, ram_rd_data, ram_wr_data;
   logic [15:0]   ram_addr, n_accept;
   logic          ram_rd_en, ram_wr_en, panel_valid, panel_ready, panel_done;
   logic          sleep_mode, cmd_busy, cmd_done, cmd_rejected, got_done, got_rej;
   dbu_panel_op_t panel_op, seen_op;
   int            n_mismatch, comparisons, acc0;
   dbu_cmd_top i_dbu_cmd_top (.clock(clock), .resetn(resetn), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .frame_end(frame_end), .ram_addr(ram_addr), .ram_rd_en(ram_rd_en),
      .ram_rd_data(ram_rd_data), .ram_wr_en(ram_wr_en), .ram_wr_data(ram_wr_data),
      .panel_valid(panel_valid), .panel_op(panel_op), .panel_ready(panel_ready),
      .panel_done(panel_done), .sleep_mode(sleep_mode), .cmd_busy(cmd_busy),
      .cmd_done(cmd_done), .cmd_rejected(cmd_rejected));
   dbu_panel_model i_dbu_panel_model (.clock(clock), .resetn(resetn), .slow(slow),
      .ram_addr(ram_addr), .ram_rd_en(ram_rd_en), .ram_wr_en(ram_wr_en),
      .ram_wr_data(ram_wr_data), .panel_valid(panel_valid), .panel_op(panel_op),
      .ram_rd_data(ram_rd_data), .panel_ready(panel_ready), .panel_done(panel_done),
      .last_op(seen_op), .n_accept(n_accept));
   // 40 MHz core clock
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task check_val(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : check_val
   task give_verdict;
      $display("Counts: comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict
   // Send a frame when idle, wait for done or reject
   task run(input dbu_bytes_t b, input int n);
      int i;
      got_done = 1'b0;
      got_rej = 1'b0;
      for (i = 0; i < 400 && cmd_busy !== 1'b0; i++) @(negedge clock);
      @(posedge clock);
      for (i = 0; i < n; i++) begin
         rx_valid <= 1'b1;
         rx_byte  <= b[i];
         @(posedge clock);
      end
      rx_valid  <= 1'b0;
      frame_end <= 1'b1;
      @(posedge clock);
      frame_end <= 1'b0;
      for (i = 0; i < 400 && !got_done && !got_rej; i++) begin
         @(negedge clock);
         got_done = (cmd_done === 1'b1);
         got_rej  = (cmd_rejected === 1'b1);
      end
   endtask : run
   task test_bitops;
      i_dbu_panel_model.mem[16'h1234] = 8'hA5;
      i_dbu_panel_model.mem[16'h3412] = 8'h5A;
      run('{8'h09, 8'h12, 8'h34, 8'h0F, 0, 0, 0}, 4);
      check_val(got_done, 1);
      check_val(i_dbu_panel_model.mem[16'h1234], 8'hAF);
      check_val(i_dbu_panel_model.mem[16'h3412], 8'h5A);
      run('{8'h0A, 8'h12, 8'h34, 8'h3C, 0, 0, 0}, 4);
      check_val(i_dbu_panel_model.mem[16'h1234], 8'h93);
   endtask : test_bitops
   // Whole and 80-row section clears, prompt and stalled
   task test_clears;
      int k;
      logic [7:0] op;
      for (k = 0; k < 8; k++) begin
         op = 8'h10 + 8'(k);
         @(posedge clock);
         slow <= k[0];
         acc0 = n_accept;
         if (k < 4) run('{op, 0, 0, 0, 0, 0, 0}, 1);
         else run('{op, 8'h00, 8'h0A, 8'h00, 8'h59, 0, 0}, 5);
         check_val(got_done, 1);
         check_val(n_accept, acc0 + 1);
         check_val(seen_op.kind, (k < 4) ? PK_CLEAR_ALL : PK_CLEAR_ROWS);
         check_val(seen_op.interior_bright, k[1] == 0);
         check_val(seen_op.border_bright, k[1] == k[0]);
         if (k >= 4) check_val({seen_op.first_row, seen_op.last_row}, 16'h0A59);
      end
      slow <= 1'b0;
   endtask : test_clears
   task test_refresh;
      run('{8'h18, 8'h43, 8'h21, 0, 0, 0, 0}, 3);
      check_val({seen_op.kind, seen_op.buf_addr}, {PK_REFRESH_ALL, 16'h4321});
      run('{8'h19, 8'h43, 8'h21, 8'h00, 8'h50, 8'h00, 8'h9F}, 7);
      check_val(seen_op.kind, PK_REFRESH_ROWS);
      check_val({seen_op.buf_addr, seen_op.first_row, seen_op.last_row}, 32'h4321509F);
   endtask : test_refresh
   // Bad ranges and a short frame leave the panel alone
   task test_reject;
      acc0 = n_accept;
      run('{8'h14, 8'h00, 8'h00, 8'h00, 8'h50, 0, 0}, 5);
      check_val(got_rej, 1);
      run('{8'h16, 8'h00, 8'h9F, 8'h00, 8'hA0, 0, 0}, 5);
      check_val(got_rej, 1);
      run('{8'h17, 8'h00, 8'h20, 8'h00, 8'h10, 0, 0}, 5);
      check_val(got_rej, 1);
      run('{8'h19, 8'h43, 8'h21, 8'h00, 8'h10, 0, 0}, 5);
      check_val(got_rej, 1);
      check_val(n_accept, acc0);
   endtask : test_reject
   task test_sleep;
      run('{8'h20, 0, 0, 0, 0, 0, 0}, 1);
      check_val({got_done, sleep_mode}, 2'h3);
      run('{8'h12, 0, 0, 0, 0, 0, 0}, 1);
      check_val({got_done, sleep_mode}, 2'h2);
   endtask : test_sleep
   // Main sequence
   initial begin
      resetn = 1'b0;
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      frame_end = 1'b0;
      slow = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (16) @(posedge clock);
      check_val({ram_addr, panel_valid, cmd_busy, sleep_mode, cmd_done}, 0);
      resetn <= 1'b1;
      test_bitops;
      test_clears;
      test_refresh;
      test_reject;
      test_sleep;
      give_verdict;
   end
   // Watchdog: ~20 commands under 100 cycles each, wide margin
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      give_verdict;
   end
endmodule : display_bitop_update_cmds_tb
